// ### hdl/cbt_host.sv
// host controller that runs command bus training on one memory die
`timescale 1ns/1ps
`default_nettype none
`include "cbt_regs.svh"
module cbt_host
   import cbt_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   // user side
   input wire logic start,
   input wire logic term_die,
   input wire logic [6:0] vref_code,
   input wire logic [5:0] ca_pattern,
   output logic busy,
   output logic done,
   output logic refused,
   output logic pass,
   output logic [5:0] echo,
   output logic [6:0] trained_vref,
   // memory side
   output logic ck_t,
   output logic ck_c,
   output logic cke,
   output logic cs,
   output logic [5:0] ca,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe,
   input wire logic dqs_t_i,
   input wire logic dqs_c_i,
   output logic dqs_t_o,
   output logic dqs_c_o,
   output logic dqs_oe
);

   // -----------------------------------------------------------------
   // timing counts in reference clock cycles
   // -----------------------------------------------------------------
   localparam logic [11:0] TMRD_CYC = 12'(`CBT_CYC(`CBT_TMRD_NS));
   localparam logic [11:0] TCAENT_CYC = 12'(`CBT_CYC(`CBT_TCAENT_NS));
   localparam logic [11:0] TVREF_CYC = 12'(`CBT_CYC(`CBT_TVREF_LONG_NS));
   localparam logic [11:0] TMRW_CYC = 12'(`CBT_CYC(`CBT_TMRW_NS));
   localparam logic [11:0] TCKCKEH_CYC = 12'(`CBT_CYC(`CBT_TCKCKEH_NS));
   localparam logic [11:0] TFB_CYC = 12'(`CBT_CYC(`CBT_TFB_NS));

   // mode register 13 values used through the sequence
   localparam logic [7:0] MR13_WR1 = 8'(1 << `CBT_MR13_FSPWR_BIT);
   localparam logic [7:0] MR13_ENTER = 8'(MR13_WR1 | (1 << `CBT_MR13_TRAIN_BIT));
   localparam logic [7:0] MR13_OP1 = 8'(MR13_WR1 | (1 << `CBT_MR13_FSPOP_BIT));

   cbt_q_s q;
   cbt_q_s d;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------

   // one process computes the whole next state
   always_comb
   begin
      logic tick_fall;
      logic cnt_zero;
      logic cmd_end;
      logic [1:0] half;
      tick_fall = 1'b0;
      cnt_zero = 1'b0;
      cmd_end = 1'b0;
      half = `CBT_HALF_SLOW;
      d = q;
      d.done = 1'b0;
      d.refused = 1'b0;

      // feedback lines pass two flops before use; lower lane ignored
      d.fb_meta = dq_i[13:8];
      d.fb_sync = q.fb_meta;

      // clock divider, CK falls on tick_fall where command beats change
      half = q.fast ? `CBT_HALF_FAST : `CBT_HALF_SLOW;
      if (q.div >= half)
      begin
         d.div = '0;
         d.pins.ck_t = ~q.pins.ck_t;
         d.pins.ck_c = q.pins.ck_t;
         tick_fall = q.pins.ck_t;
      end
      else
      begin
         d.div = q.div + 2'h1;
      end

      cnt_zero = (q.cnt == '0);
      if (!cnt_zero)
      begin
         d.cnt = q.cnt - 12'h001;
      end

      // two-half mode register write, one beat per CK period
      if (tick_fall && (q.st == ST_SET_WR || q.st == ST_ENTRY || q.st == ST_EXIT_MRW ||
         q.st == ST_WRITE_TRAINED || q.st == ST_SWITCH_OP))
      begin
         d.beat = q.beat + 3'h1;
         unique case (q.beat)
            3'h0:
            begin
               d.pins.cs = 1'b1;
               d.pins.ca = {q.mr_op[7], `CBT_MRW1_CODE};
            end
            3'h1:
            begin
               d.pins.cs = 1'b0;
               d.pins.ca = q.mr_addr;
            end
            3'h2:
            begin
               d.pins.cs = 1'b1;
               d.pins.ca = {q.mr_op[6], `CBT_MRW2_CODE};
            end
            3'h3:
            begin
               d.pins.cs = 1'b0;
               d.pins.ca = q.mr_op[5:0];
            end
            default:
            begin
               // second half done: the write takes effect as one update
               d.pins.cs = 1'b0;
               d.pins.ca = '0;
               d.beat = '0;
               cmd_end = 1'b1;
            end
         endcase
      end

      unique case (q.st)
         ST_IDLE:
         begin
            // CKE stays high while idle, so self refresh entry is legal
            d.pins.cke = 1'b1;
            if (start)
            begin
               if (!term_die && !q.term_done)
               begin
                  d.refused = 1'b1;
               end
               else
               begin
                  d.term = term_die;
                  d.vref = vref_code;
                  d.pattern = ca_pattern;
                  d.busy = 1'b1;
                  d.fast = 1'b0;
                  d.beat = '0;
                  d.mr_addr = `CBT_MR13_ADDR;
                  d.mr_op = MR13_WR1;
                  d.st = ST_SET_WR;
               end
            end
         end
         ST_SET_WR:
         begin
            // select write set one before training
            if (cmd_end)
            begin
               d.mr_op = MR13_ENTER;
               d.st = ST_ENTRY;
            end
         end
         ST_ENTRY:
         begin
            if (cmd_end)
            begin
               d.cnt = TMRD_CYC;
               d.st = ST_WAIT_MRD;
            end
         end
         ST_WAIT_MRD:
         begin
            // drop CKE and switch CK to the fast point
            if (cnt_zero)
            begin
               d.pins.cke = 1'b0;
               d.fast = 1'b1;
               d.cnt = TCAENT_CYC;
               d.st = ST_WAIT_ENT;
            end
         end
         ST_WAIT_ENT:
         begin
            // present the reference code one cycle ahead of the strobe
            if (cnt_zero)
            begin
               d.pins.dq_o = q.vref;
               d.pins.dq_oe = 1'b1;
               d.pins.dqs_oe = 1'b1;
               d.cnt = `CBT_DQS_EDGES;
               d.st = ST_VREF_DRIVE;
            end
         end
         ST_VREF_DRIVE:
         begin
            // two full strobe pulses, since the first edge may be missed
            if (cnt_zero)
            begin
               d.pins.dqs_t = 1'b0;
               d.pins.dqs_c = 1'b1;
               d.cnt = TVREF_CYC;
               d.st = ST_VREF_SETTLE;
            end
            else
            begin
               d.pins.dqs_t = ~q.pins.dqs_t;
               d.pins.dqs_c = q.pins.dqs_t;
            end
         end
         ST_VREF_SETTLE:
         begin
            // long settle before any CA value is trusted
            if (cnt_zero)
            begin
               d.beat = '0;
               d.st = ST_CA_DRIVE;
            end
         end
         ST_CA_DRIVE:
         begin
            // one CK period of CS high with the pattern on CA
            if (tick_fall)
            begin
               if (q.beat == '0)
               begin
                  d.pins.cs = 1'b1;
                  d.pins.ca = q.pattern;
                  d.beat = 3'h1;
               end
               else
               begin
                  d.pins.cs = 1'b0;
                  d.beat = '0;
                  d.cnt = TFB_CYC;
                  d.st = ST_CA_FB;
               end
            end
         end
         ST_CA_FB:
         begin
            // compare reflected CA against what was sent, CA0 on DQ8
            if (cnt_zero)
            begin
               d.echo = q.fb_sync;
               d.pass = (q.fb_sync == q.pattern);
               d.pins.cs = 1'b0;
               d.pins.ca = '0;
               d.fast = 1'b0;
               d.cnt = TCKCKEH_CYC;
               d.st = ST_DESEL;
            end
         end
         ST_DESEL:
         begin
            // CS and CA held low for the deselect time, then CKE high
            if (cnt_zero)
            begin
               d.pins.cke = 1'b1;
               d.pins.dq_oe = 1'b0;
               d.pins.dqs_oe = 1'b0;
               d.pins.dq_o = '0;
               d.cnt = TVREF_CYC;
               d.st = ST_EXIT_SETTLE;
            end
         end
         ST_EXIT_SETTLE:
         begin
            // clear the training bit after the long settle
            if (cnt_zero)
            begin
               d.beat = '0;
               d.mr_addr = `CBT_MR13_ADDR;
               d.mr_op = MR13_WR1;
               d.st = ST_EXIT_MRW;
            end
         end
         ST_EXIT_MRW:
         begin
            if (cmd_end)
            begin
               d.cnt = TMRW_CYC;
               d.st = ST_WAIT_MRW;
            end
         end
         ST_WAIT_MRW:
         begin
            // device dropped the trained value, so write it back
            if (cnt_zero)
            begin
               d.mr_addr = `CBT_MR12_ADDR;
               d.mr_op = {1'b0, q.vref};
               d.st = ST_WRITE_TRAINED;
            end
         end
         ST_WRITE_TRAINED:
         begin
            if (cmd_end)
            begin
               d.mr_addr = `CBT_MR13_ADDR;
               d.mr_op = MR13_OP1;
               d.st = ST_SWITCH_OP;
            end
         end
         ST_SWITCH_OP:
         begin
            // trained set point active, CK to the fast point
            if (cmd_end)
            begin
               d.fast = 1'b1;
               d.st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            d.done = 1'b1;
            d.busy = 1'b0;
            d.term_done = q.term_done | q.term;
            d.st = ST_IDLE;
         end
      endcase

      // synchronous reset to a quiet bus with CKE high
      if (!rst_b)
      begin
         d = '0;
         d.st = ST_IDLE;
         d.pins.cke = `CBT_CKE_RST;
         d.pins.ck_c = 1'b1;
         d.pins.dqs_c = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------

   // every flop of the block
   always_ff @(posedge ref_clk)
   begin
      q <= d;
   end

   // -----------------------------------------------------------------
   // outputs straight from flops
   // -----------------------------------------------------------------

   // user side
   assign busy = q.busy;
   assign done = q.done;
   assign refused = q.refused;
   assign pass = q.pass;
   assign echo = q.echo;
   assign trained_vref = q.vref;

   // memory side; only the low seven data lines are ever driven
   assign ck_t = q.pins.ck_t;
   assign ck_c = q.pins.ck_c;
   assign cke = q.pins.cke;
   assign cs = q.pins.cs;
   assign ca = q.pins.ca;
   assign dq_o = {9'h000, q.pins.dq_o};
   assign dq_oe = {9'h000, {7{q.pins.dq_oe}}};
   assign dqs_t_o = q.pins.dqs_t;
   assign dqs_c_o = q.pins.dqs_c;
   assign dqs_oe = q.pins.dqs_oe;

endmodule
`default_nettype wire

// ### hdl/cbt_regs.svh
// constants for the command bus training host controller
// Summary of operation
// - before training, set the write-set bit so set one receives high-frequency values.
// - enter training with a first-half then second-half write setting the training bit.
// - after the mode write delay, drop CKE; device switches to operating set one.
// - at least one reference setting is applied before the CA step.
// - wait the long settling time after a new reference before trusting feedback.
// - exit: CKE high, long settle, clear training bit, wait mode write time.
// - after exit, write trained values into the chosen write set by write pairs.
// - training starts from idle or self refresh with CKE high at entry.
// - single rank: CKE low, fast CK, train, slow CK back on exit.
// - finish by switching to the trained operating set point, then fast CK.
// - a terminating die is flagged by mode register zero bit seven being one; the host reads no mode register and takes it from the term_die input.
// - in multi-rank systems the terminating rank is trained first.
// - hold CS and CA low for the deselect time, CK slow, before raising CKE.
// - present each reference code with at least two consecutive strobe pulses.
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH
`define CBT_CLK_PS 4000
`define CBT_CYC(ns) ((((ns) * 1000) + `CBT_CLK_PS - 1) / `CBT_CLK_PS)
`define CBT_TVREF_LONG_NS 250
`define CBT_TMRD_NS 14
`define CBT_TCAENT_NS 250
`define CBT_TMRW_NS 10
`define CBT_TCKCKEH_NS 10
`define CBT_TFB_NS 20
`define CBT_MR12_ADDR 6'h0C
`define CBT_MR13_ADDR 6'h0D
`define CBT_MR13_TRAIN_BIT 0
`define CBT_MR13_FSPWR_BIT 6
`define CBT_MR13_FSPOP_BIT 7
`define CBT_MRW1_CODE 5'h06
`define CBT_MRW2_CODE 5'h08
`define CBT_HALF_SLOW 2'h3
`define CBT_HALF_FAST 2'h0
`define CBT_DQS_EDGES 12'h004
`define CBT_CKE_RST 1'h1
`endif

// ### hdl/cbt_pkg.sv
// types for the command bus training host controller
package cbt_pkg;
   typedef enum logic [15:0] {
      ST_IDLE = 16'h0001, ST_SET_WR = 16'h0002, ST_ENTRY = 16'h0004,
      ST_WAIT_MRD = 16'h0008, ST_WAIT_ENT = 16'h0010, ST_VREF_DRIVE = 16'h0020,
      ST_VREF_SETTLE = 16'h0040, ST_CA_DRIVE = 16'h0080, ST_CA_FB = 16'h0100,
      ST_DESEL = 16'h0200, ST_EXIT_SETTLE = 16'h0400, ST_EXIT_MRW = 16'h0800,
      ST_WAIT_MRW = 16'h1000, ST_WRITE_TRAINED = 16'h2000, ST_SWITCH_OP = 16'h4000,
      ST_DONE = 16'h8000
   } cbt_state_e;
   typedef struct packed {
      logic ck_t;
      logic ck_c;
      logic cke;
      logic cs;
      logic [5:0] ca;
      logic [6:0] dq_o;
      logic dq_oe;
      logic dqs_t;
      logic dqs_c;
      logic dqs_oe;
   } cbt_pins_s;
   typedef struct packed {
      cbt_state_e st;
      logic [2:0] beat;
      logic [1:0] div;
      logic fast;
      logic [11:0] cnt;
      cbt_pins_s pins;
      logic [5:0] mr_addr;
      logic [7:0] mr_op;
      logic [5:0] fb_meta;
      logic [5:0] fb_sync;
      logic [5:0] echo;
      logic pass;
      logic done;
      logic refused;
      logic busy;
      logic [6:0] vref;
      logic [5:0] pattern;
      logic term;
      logic term_done;
   } cbt_q_s;
endpackage

// ### verif/cbt_die_model.sv
// behavioural memory die answering command bus training
`timescale 1ns/1ps
`default_nettype none
module cbt_die_model (
   input wire logic ck_t,
   input wire logic cke,
   input wire logic cs,
   input wire logic [5:0] ca,
   input wire logic [15:0] dq,
   input wire logic dqs_t,
   input wire logic corrupt,
   output logic [15:0] dq_drv,
   output logic [15:0] dq_en,
   output logic fsp
);
   logic [7:0] mr13 = 8'h00;
   logic [6:0] mr12 = 7'h00;
   logic [6:0] cap = 7'h00;
   logic [5:0] lat = 6'h00;
   logic [5:0] addr = 6'h00;
   logic [1:0] stage = 2'h0;
   logic op7 = 1'b0;
   logic op6 = 1'b0;
   // time of the last strobe edge, to judge whether the reference has settled
   time last_dqs = 0;
   // set point zero at power-up, alternate set while trained, back on exit
   assign fsp = (mr13[0] && !cke) ? !mr13[7] : mr13[7];
   // latched command bus shown without a clock; upper lanes left floating
   assign dq_en = {2'h0, {6{mr13[0] && !cke}}, 8'h00};
   assign dq_drv = {2'h0, lat ^ {5'h00, corrupt}, 8'h00};
   // mode write decoder, applied only after the second half
   always @(posedge ck_t)
      if (cke)
      begin
         if (cs && ca[4:0] == 5'h06)
            {stage, op7} <= {2'h1, ca[5]};
         else if (stage == 2'h1)
            {stage, addr} <= {2'h2, ca};
         else if (stage == 2'h2 && cs && ca[4:0] == 5'h08)
            {stage, op6} <= {2'h3, ca[5]};
         else if (stage == 2'h3)
         begin
            stage <= 2'h0;
            if (addr == 6'h0C) mr12 <= {op6, ca};
            if (addr == 6'h0D) mr13 <= {op7, op6, ca};
         end
      end
      else if (mr13[0] && cs)
         // an unsettled reference latches garbage, so early sampling shows up
         lat <= (($time - last_dqs) < 250) ? ~ca : ca;
   // reference code taken on every strobe toggle in training
   always @(dqs_t)
      if (mr13[0] && !cke)
      begin
         // lanes taken as terminated inputs while the code arrives
         cap <= dq[6:0];
         last_dqs <= $time;
      end
endmodule
`default_nettype wire

// ### verif/cbt_host_chk.sv
// concurrent checks on the training host ports
`timescale 1ns/1ps
`default_nettype none
module cbt_host_chk (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic term_die,
   input wire logic busy,
   input wire logic done,
   input wire logic refused,
   input wire logic [6:0] trained_vref,
   input wire logic cke,
   input wire logic cs,
   input wire logic [5:0] ca,
   input wire logic [15:0] dq_o,
   input wire logic [15:0] dq_oe,
   input wire logic dqs_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic [3:0] desel_q;
   logic [3:0] desel_d;
   // ---------------------------------------------
   // deselect time counter ahead of cke rising
   // ---------------------------------------------
   always_comb desel_d = (cs || ca != 6'h00) ? 4'h0 : desel_q + {3'h0, desel_q != 4'hF};
   always_ff @(posedge ref_clk) desel_q <= rst_b ? desel_d : 4'h0;
   sequence s_mrw_first;
      cs && cke && ca[4:0] == 5'h06;
   endsequence
   sequence s_mrw_second;
      cs && cke && ca[4:0] == 5'h08;
   endsequence
   property p_mrw; $rose(cs) ##0 s_mrw_first |-> ##[1:40] s_mrw_second; endproperty
   property p_desel; $rose(cke) |-> desel_q >= 4'h3; endproperty
   property p_cke_busy; $fell(cke) |-> busy; endproperty
   property p_strobe; dqs_oe |-> !cke && dq_oe[6:0] == 7'h7F; endproperty
   property p_code; dq_oe[0] |-> dq_o[6:0] == trained_vref; endproperty
   property p_upper; dq_oe[15:7] == 9'h000 && dq_o[15:7] == 9'h000; endproperty
   property p_done; done |-> !busy && $past(busy); endproperty
   property p_refused; refused |-> $past(start) && !$past(term_die) && !busy; endproperty
   property p_start; start && !busy && !done && term_die |=> busy; endproperty
   a_mrw: assert property (p_mrw) else $error("mode write halves out of order");
   a_desel: assert property (p_desel) else $error("cke rose too soon");
   a_cke_busy: assert property (p_cke_busy) else $error("cke fell while idle");
   a_strobe: assert property (p_strobe) else $error("strobe without code");
   a_code: assert property (p_code) else $error("wrong reference code");
   a_upper: assert property (p_upper) else $error("upper lanes driven");
   a_done: assert property (p_done) else $error("done without busy");
   a_refused: assert property (p_refused) else $error("bad refusal");
   a_start: assert property (p_start) else $error("start not taken");
endmodule
bind cbt_host cbt_host_chk i_cbt_host_chk (.ref_clk, .rst_b, .start, .term_die, .busy, .done,
   .refused, .trained_vref, .cke, .cs, .ca, .dq_o, .dq_oe, .dqs_oe);
`default_nettype wire

// ### verif/cbt_host_test.sv
// self-checking bench for the training host against a die model
`timescale 1ns/1ps
`default_nettype none
module cbt_host_test;
   import cbt_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, start = 1'b0, term_die = 1'b0, corrupt = 1'b0;
   logic [6:0] vref_code = 7'h00;
   logic [5:0] ca_pattern = 6'h00;
   logic busy, done, refused, pass, ck_t, ck_c, cke, cs, dqs_t_o, dqs_c_o, dqs_oe, fsp;
   logic [5:0] echo, ca;
   logic [6:0] trained_vref;
   logic [15:0] dq_o, dq_oe, dq_w, dq_drv, dq_en;
   logic [15:0] flt = 16'h0000;
   logic [1:0] res;
   logic [6:0] vtab [3] = '{7'h2A, 7'h7F, 7'h00};
   logic [5:0] ptab [3] = '{6'h15, 6'h3F, 6'h00};
   int failures = 0, tests_run = 0;
   initial forever #2 ref_clk = ~ref_clk;
   // wire level: host, then die, else a changing pattern on released lanes
   assign dq_w = (dq_oe & dq_o) | (~dq_oe & dq_en & dq_drv) | (~dq_oe & ~dq_en & flt);
   always @(posedge ref_clk) flt <= ~dq_w;
   cbt_host i_cbt_host (.ref_clk, .rst_b, .start, .term_die, .vref_code, .ca_pattern, .busy,
      .done, .refused, .pass, .echo, .trained_vref, .ck_t, .ck_c, .cke, .cs, .ca, .dq_i(dq_w),
      .dq_o, .dq_oe, .dqs_t_i(dqs_t_o), .dqs_c_i(dqs_c_o), .dqs_t_o, .dqs_c_o, .dqs_oe);
   cbt_die_model i_cbt_die_model (.ck_t, .cke, .cs, .ca, .dq(dq_w), .dqs_t(dqs_t_o), .corrupt,
      .dq_drv, .dq_en, .fsp);
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic print_verdict();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   // one training request, waits for done or refusal
   task automatic run(input logic td, input logic [6:0] v, input logic [5:0] p);
      int i;
      @(posedge ref_clk);
      start <= 1'b1;
      term_die <= td;
      vref_code <= v;
      ca_pattern <= p;
      @(posedge ref_clk);
      start <= 1'b0;
      res = 2'h0;
      for (i = 0; i < 5000 && res == 2'h0; i++)
      begin
         @(negedge ref_clk);
         if (refused === 1'b1) res = 2'h2;
         if (done === 1'b1) res = 2'h1;
      end
      if (res == 2'h0)
      begin
         $display("[ERR] %0t no answer", $time);
         failures++;
         print_verdict();
      end
   endtask
   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      chk({cke, cs, busy, done, refused, pass, dqs_oe, |dq_oe}, 8'h80);
      chk({1'b0, fsp, echo}, 8'h00);
      run(1'b0, 7'h11, 6'h01);
      chk({6'h00, res}, 8'h02);
      run(1'b1, 7'h55, 6'h2A);
      chk({res, echo}, {2'h1, 6'h2A});
      chk({pass, trained_vref}, 8'hD5);
      chk({1'b0, i_cbt_die_model.cap}, 8'h55);
      chk({1'b0, i_cbt_die_model.mr12}, 8'h55);
      chk(i_cbt_die_model.mr13, 8'hC0);
      chk({7'h00, fsp}, 8'h01);
      for (int k = 0; k < 3; k++)
      begin
         run(1'b0, vtab[k], ptab[k]);
         chk({res, echo}, {2'h1, ptab[k]});
         chk({pass, trained_vref}, {1'b1, vtab[k]});
      end
      corrupt <= 1'b1;
      run(1'b0, 7'h40, 6'h3F);
      chk({pass, 1'b0, echo}, 8'h3E);
      print_verdict();
   end
endmodule
`default_nettype wire
